// >>> common/supply_sequencer_consts.svh
// register map, field positions, reset values and timing constants
`ifndef SUPPLY_SEQUENCER_CONSTS_SVH
`define SUPPLY_SEQUENCER_CONSTS_SVH

`define ADR_LOW_THR0    8'h00
`define ADR_HIGH_THR0   8'h04
`define ADR_STEP_SEL    8'h08
`define ADR_RETRY_CFG   8'h09
`define ADR_TMO_CFG     8'h0A
`define ADR_RAMP_CFG    8'h12
`define ADR_SHUT_CFG    8'h13
`define ADR_STATUS      8'h14

`define REG_RST         8'h00
`define RETRY_LATCH_BIT 5
`define RETRY_DLY_HI    4
`define RETRY_DLY_LO    2
`define TMO_UP_HI       7
`define TMO_UP_LO       6
`define TMO_DN_HI       5
`define TMO_DN_LO       4
`define SLEW_HI         7
`define SLEW_LO         6
`define SHUT_REV_BIT    7
`define DISCH_HI        6
`define DISCH_LO        3
`define STEP_HI         7

`define COARSE_BASE_MV  13'h03E8
`define COARSE_STEP_MV  13'h0014
`define FINE_BASE_MV    13'h01F4
`define FINE_STEP_MV    13'h000A

`define CLK_PERIOD_NS   25
`define TICK_NS         1000
`define TICK_CYC        (`TICK_NS / `CLK_PERIOD_NS)

`endif

// >>> common/supply_sequencer_pkg.sv
// types shared by the supply sequencer
package supply_sequencer_pkg;
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_UP    = 6'h02,
      ST_ON    = 6'h04,
      ST_DOWN  = 6'h08,
      ST_RETRY = 6'h10,
      ST_LATCH = 6'h20
   } seq_state_t;
endpackage : supply_sequencer_pkg

// >>> verilog/supply_sequencer_fault_config.sv
// supply sequencer configuration registers, fault timers and retry control
// Notes on behaviour
// - style bit 1: ramp down in reverse order; 0: fast gate pulldown.
// - bits 6..3 enable discharge pulldown on outputs 1..4.
// - power-up timeout codes 00..11 give 25, 50, 100, 200 ms.
// - power-down timeout uses the same four-value mapping.
// - slew code 00..11 gives 800, 400, 200, 100 V/s both ways.
// - trip level from 1 V in 20 mV or 0.5 V in 10 mV steps.
// - 8-bit low codes at 00h..03h, input 1 high code at 04h.
// - any input out of window during power-up, on or power-down shuts all outputs and raises fault.
// - retry bit 1 latches off after fault, 0 retries after delay.
// - retry delay codes map 25 us up to 1600 ms.
// - step bits 7..4 pick fine (1) or coarse (0) per input.
// - power-up starts only with all inputs in window and enable high.
// - each power-up ramp must finish before timeout or gates go off.
// - during retry wait gates stay off and fault stays asserted.
`timescale 1ns/1ps
`default_nettype none
`include "supply_sequencer_consts.svh"

module supply_sequencer_fault_config #(
   parameter int TMO_25MS_US    = 25000,
   parameter int TMO_50MS_US    = 50000,
   parameter int TMO_100MS_US   = 100000,
   parameter int TMO_200MS_US   = 200000,
   parameter int RETRY_25US     = 25,
   parameter int RETRY_12M5_US  = 12500,
   parameter int RETRY_400MS_US = 400000,
   parameter int RETRY_1600MS_US = 1600000
) (
   input  wire logic        clk_i,           // 40 MHz clock
   input  wire logic        resetn_i,        // async reset, active low
   input  wire logic [7:0]  reg_addr_i,      // register address
   input  wire logic [7:0]  reg_wdata_i,     // write data
   input  wire logic        reg_wr_i,        // write strobe
   input  wire logic        reg_rd_i,        // read strobe
   output logic      [7:0]  reg_rdata_o,     // read data, next cycle
   input  wire logic [51:0] in_mv_i,         // four 13-bit input levels, mV
   input  wire logic        enable_i,        // combined internal enable
   input  wire logic        ramp_done_i,     // power-up ramp complete
   input  wire logic        outputs_low_i,   // all outputs near ground
   output logic             gate_on_o,       // gate drive enabled
   output logic             fast_pulldown_o, // quick gate pulldown
   output logic             reverse_down_o,  // reverse-order ramp down
   output logic      [3:0]  discharge_en_o,  // output discharge pulldowns
   output logic      [1:0]  slew_sel_o,      // reference ramp rate code
   output logic             fault_o          // failure flag
);
   localparam int TW = 21;

   logic [7:0] low_thr_r [4];
   logic [7:0] high_thr_r [4];
   logic [7:0] step_sel_r;
   logic [7:0] retry_cfg_r;
   logic [7:0] tmo_cfg_r;
   logic [7:0] ramp_cfg_r;
   logic [7:0] shut_cfg_r;
   supply_sequencer_pkg::seq_state_t state_r;
   supply_sequencer_pkg::seq_state_t state_nxt;
   logic [5:0]    tick_cnt_r;
   logic          tick;
   logic [TW-1:0] timer_r;
   logic          in_window;
   logic          start_phase;

   function automatic logic [12:0] trip_level(input logic [7:0] code,
                                              input logic fine);
      if (fine)
         trip_level = 13'(`FINE_BASE_MV + code * `FINE_STEP_MV);
      else
         trip_level = 13'(`COARSE_BASE_MV + code * `COARSE_STEP_MV);
   endfunction : trip_level

   function automatic logic [TW-1:0] fault_tmo(input logic [1:0] code);
      unique case (code)
         2'h0: fault_tmo = TW'(TMO_25MS_US);
         2'h1: fault_tmo = TW'(TMO_50MS_US);
         2'h2: fault_tmo = TW'(TMO_100MS_US);
         2'h3: fault_tmo = TW'(TMO_200MS_US);
      endcase
   endfunction : fault_tmo

   function automatic logic [TW-1:0] retry_dly(input logic [2:0] code);
      unique case (code)
         3'h0: retry_dly = TW'(RETRY_25US);
         3'h1: retry_dly = TW'(RETRY_12M5_US);
         3'h2: retry_dly = TW'(TMO_25MS_US);
         3'h3: retry_dly = TW'(TMO_50MS_US);
         3'h4: retry_dly = TW'(TMO_100MS_US);
         3'h5: retry_dly = TW'(TMO_200MS_US);
         3'h6: retry_dly = TW'(RETRY_400MS_US);
         3'h7: retry_dly = TW'(RETRY_1600MS_US);
      endcase
   endfunction : retry_dly

   // register writes
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < 4; i++) begin
            low_thr_r[i]  <= `REG_RST;
            high_thr_r[i] <= `REG_RST;
         end
         step_sel_r  <= `REG_RST;
         retry_cfg_r <= `REG_RST;
         tmo_cfg_r   <= `REG_RST;
         ramp_cfg_r  <= `REG_RST;
         shut_cfg_r  <= `REG_RST;
      end else if (reg_wr_i) begin
         for (int i = 0; i < 4; i++) begin
            if (reg_addr_i == `ADR_LOW_THR0 + 8'(i))
               low_thr_r[i] <= reg_wdata_i;
            if (reg_addr_i == `ADR_HIGH_THR0 + 8'(i))
               high_thr_r[i] <= reg_wdata_i;
         end
         if (reg_addr_i == `ADR_STEP_SEL)
            step_sel_r <= reg_wdata_i;
         if (reg_addr_i == `ADR_RETRY_CFG)
            retry_cfg_r <= reg_wdata_i;
         if (reg_addr_i == `ADR_TMO_CFG)
            tmo_cfg_r <= reg_wdata_i;
         if (reg_addr_i == `ADR_RAMP_CFG)
            ramp_cfg_r <= reg_wdata_i;
         if (reg_addr_i == `ADR_SHUT_CFG)
            shut_cfg_r <= reg_wdata_i;
      end
   end

   // register reads; unmapped addresses return zero
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_o <= 8'h00;
         for (int i = 0; i < 4; i++) begin
            if (reg_addr_i == `ADR_LOW_THR0 + 8'(i))
               reg_rdata_o <= low_thr_r[i];
            if (reg_addr_i == `ADR_HIGH_THR0 + 8'(i))
               reg_rdata_o <= high_thr_r[i];
         end
         unique case (reg_addr_i)
            `ADR_STEP_SEL:  reg_rdata_o <= step_sel_r;
            `ADR_RETRY_CFG: reg_rdata_o <= retry_cfg_r;
            `ADR_TMO_CFG:   reg_rdata_o <= tmo_cfg_r;
            `ADR_RAMP_CFG:  reg_rdata_o <= ramp_cfg_r;
            `ADR_SHUT_CFG:  reg_rdata_o <= shut_cfg_r;
            `ADR_STATUS:    reg_rdata_o <= {2'h0, state_r};
            default: ;
         endcase
      end
   end

   // window check over all four inputs
   always_comb begin
      in_window = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (in_mv_i[13*i +: 13] <
             trip_level(low_thr_r[i], step_sel_r[`STEP_HI-i]) ||
             in_mv_i[13*i +: 13] >
             trip_level(high_thr_r[i], step_sel_r[`STEP_HI-i]))
            in_window = 1'b0;
      end
   end

   // microsecond tick
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i)
         tick_cnt_r <= 6'h00;
      else if (tick)
         tick_cnt_r <= 6'h00;
      else
         tick_cnt_r <= tick_cnt_r + 6'h01;
   end
   assign tick = (tick_cnt_r == 6'(`TICK_CYC - 1));

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         supply_sequencer_pkg::ST_IDLE:
            if (in_window && enable_i)
               state_nxt = supply_sequencer_pkg::ST_UP;
         supply_sequencer_pkg::ST_UP:
            if (!in_window || (timer_r == '0))
               state_nxt = retry_cfg_r[`RETRY_LATCH_BIT] ?
                  supply_sequencer_pkg::ST_LATCH :
                  supply_sequencer_pkg::ST_RETRY;
            else if (ramp_done_i)
               state_nxt = supply_sequencer_pkg::ST_ON;
         supply_sequencer_pkg::ST_ON:
            if (!in_window)
               state_nxt = retry_cfg_r[`RETRY_LATCH_BIT] ?
                  supply_sequencer_pkg::ST_LATCH :
                  supply_sequencer_pkg::ST_RETRY;
            else if (!enable_i)
               state_nxt = supply_sequencer_pkg::ST_DOWN;
         supply_sequencer_pkg::ST_DOWN:
            if (!in_window || (timer_r == '0))
               state_nxt = retry_cfg_r[`RETRY_LATCH_BIT] ?
                  supply_sequencer_pkg::ST_LATCH :
                  supply_sequencer_pkg::ST_RETRY;
            else if (outputs_low_i)
               state_nxt = supply_sequencer_pkg::ST_IDLE;
         supply_sequencer_pkg::ST_RETRY:
            if (timer_r == '0)
               state_nxt = supply_sequencer_pkg::ST_IDLE;
         supply_sequencer_pkg::ST_LATCH:
            if (!enable_i)
               state_nxt = supply_sequencer_pkg::ST_IDLE;
         default:
            state_nxt = supply_sequencer_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i)
         state_r <= supply_sequencer_pkg::ST_IDLE;
      else
         state_r <= state_nxt;
   end

   assign start_phase = (state_nxt != state_r);

   // phase timer, reloaded on every phase entry
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         timer_r <= '0;
      end else if (start_phase) begin
         unique case (state_nxt)
            supply_sequencer_pkg::ST_UP:
               timer_r <= fault_tmo(
                  tmo_cfg_r[`TMO_UP_HI:`TMO_UP_LO]);
            supply_sequencer_pkg::ST_DOWN:
               timer_r <= fault_tmo(
                  tmo_cfg_r[`TMO_DN_HI:`TMO_DN_LO]);
            supply_sequencer_pkg::ST_RETRY:
               timer_r <= retry_dly(
                  retry_cfg_r[`RETRY_DLY_HI:`RETRY_DLY_LO]);
            default:
               timer_r <= '0;
         endcase
      end else if (tick && timer_r != '0) begin
         timer_r <= timer_r - TW'(1);
      end
   end

   // registered pin outputs
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gate_on_o       <= 1'b0;
         fast_pulldown_o <= 1'b0;
         reverse_down_o  <= 1'b0;
         discharge_en_o  <= 4'h0;
         slew_sel_o      <= 2'h0;
         fault_o         <= 1'b0;
      end else begin
         gate_on_o <= (state_r == supply_sequencer_pkg::ST_UP) ||
                      (state_r == supply_sequencer_pkg::ST_ON) ||
                      (state_r == supply_sequencer_pkg::ST_DOWN &&
                       shut_cfg_r[`SHUT_REV_BIT]);
         fast_pulldown_o <= (state_r == supply_sequencer_pkg::ST_RETRY) ||
                            (state_r == supply_sequencer_pkg::ST_LATCH) ||
                            (state_r == supply_sequencer_pkg::ST_DOWN &&
                             !shut_cfg_r[`SHUT_REV_BIT]);
         reverse_down_o <= (state_r == supply_sequencer_pkg::ST_DOWN) &&
                           shut_cfg_r[`SHUT_REV_BIT];
         discharge_en_o <= {shut_cfg_r[`DISCH_LO], shut_cfg_r[`DISCH_LO+1],
                            shut_cfg_r[`DISCH_HI-1],
                            shut_cfg_r[`DISCH_HI]};
         slew_sel_o <= ramp_cfg_r[`SLEW_HI:`SLEW_LO];
         fault_o <= (state_r == supply_sequencer_pkg::ST_RETRY) ||
                    (state_r == supply_sequencer_pkg::ST_LATCH);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_trip_active;
      !in_window && (state_r == supply_sequencer_pkg::ST_ON);
   endsequence
   sequence s_fault_out;
      ##2 fault_o && !gate_on_o;
   endsequence

   a_trip_shuts_gates: assert property (s_trip_active |-> s_fault_out)
      else $error("input trip did not shut gates");
   a_start_needs_window: assert property (
      state_r == supply_sequencer_pkg::ST_IDLE && in_window && enable_i
      |=> state_r == supply_sequencer_pkg::ST_UP ##1 gate_on_o)
      else $error("power-up not started with window and enable");
   a_up_timeout_fault: assert property (
      state_r == supply_sequencer_pkg::ST_UP && timer_r == '0 &&
      in_window |=> state_r != supply_sequencer_pkg::ST_ON &&
      state_r != supply_sequencer_pkg::ST_UP)
      else $error("power-up timeout ignored");
   a_retry_gates_off: assert property (
      state_r == supply_sequencer_pkg::ST_RETRY |=> !gate_on_o && fault_o)
      else $error("gates on during retry wait");
   a_latch_holds: assert property (
      state_r == supply_sequencer_pkg::ST_LATCH && enable_i
      |=> state_r == supply_sequencer_pkg::ST_LATCH)
      else $error("latch-off released while enabled");
   a_up_timer_load: assert property (
      state_r == supply_sequencer_pkg::ST_IDLE &&
      state_nxt == supply_sequencer_pkg::ST_UP
      |=> timer_r ==
          fault_tmo($past(tmo_cfg_r[`TMO_UP_HI:`TMO_UP_LO])))
      else $error("power-up timer loaded wrongly");
   a_retry_timer_load: assert property (
      state_nxt == supply_sequencer_pkg::ST_RETRY &&
      state_r != supply_sequencer_pkg::ST_RETRY
      |=> timer_r ==
          retry_dly($past(retry_cfg_r[`RETRY_DLY_HI:`RETRY_DLY_LO])))
      else $error("retry timer loaded wrongly");
   a_fast_down_style: assert property (
      state_r == supply_sequencer_pkg::ST_DOWN && !shut_cfg_r[`SHUT_REV_BIT]
      |=> fast_pulldown_o && !gate_on_o)
      else $error("fast pulldown not applied");
   a_discharge_map: assert property (
      discharge_en_o[0] == $past(shut_cfg_r[`DISCH_HI]) &&
      discharge_en_o[3] == $past(shut_cfg_r[`DISCH_LO]))
      else $error("discharge bit mapping wrong");
endmodule : supply_sequencer_fault_config

`default_nettype wire

// >>> tb/rail_switch_model.sv
// behavioural pass transistors and rails on the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none

module rail_switch_model (
   input  wire logic       clk_i,           // system clock
   input  wire logic       resetn_i,        // async reset, active low
   input  wire logic       gate_on_i,       // gate drive on
   input  wire logic       fast_pulldown_i, // quick gate pulldown
   input  wire logic       reverse_down_i,  // controlled ramp down
   input  wire logic [1:0] slew_sel_i,      // ramp rate code
   input  wire logic       stall_i,         // freeze the rails
   output logic            ramp_done_o,     // rails fully up
   output logic            outputs_low_o    // rails near ground
);
   logic [8:0] level_r;
   logic [8:0] step;

   // slower code gives a smaller step per clock
   always_comb step = 9'h008 >> slew_sel_i;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         level_r <= 9'h000;
      end else if (stall_i) begin
         level_r <= level_r;
      end else if (gate_on_i && !reverse_down_i) begin
         level_r <= (level_r + step > 9'h0FF) ? 9'h0FF : level_r + step;
      end else if (fast_pulldown_i) begin
         level_r <= 9'h000;
      end else begin
         level_r <= (level_r > step) ? level_r - step : 9'h000;
      end
   end

   always_comb ramp_done_o = (level_r == 9'h0FF);
   always_comb outputs_low_o = (level_r == 9'h000);
endmodule : rail_switch_model

`default_nettype wire

// >>> tb/tb_top.sv
// testbench: register access, sequencing and fault timing
`timescale 1ns/1ps
`default_nettype none
`include "supply_sequencer_consts.svh"

module tb_top;
   localparam int TK = `TICK_CYC;
   int          tmo_us [4] = '{20, 40, 80, 160};
   int          rty_us [3] = '{5, 20, 40};
   int          rty_cd [3] = '{0, 2, 3};
   logic [7:0]  adr [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h09,
                             8'h0A, 8'h12, 8'h13, 8'h30};
   logic [7:0]  val [10] = '{8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'hC8, 8'h00,
                             8'h00, 8'hC0, 8'h48, 8'hA5};
   logic        clk_i, resetn_i, reg_wr_i, reg_rd_i, enable_i, stall;
   logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, rd_v;
   logic [51:0] in_mv_i;
   logic        ramp_done_i, outputs_low_i, gate_on_o, fast_pulldown_o;
   logic        reverse_down_o, fault_o;
   logic [3:0]  discharge_en_o;
   logic [1:0]  slew_sel_o;
   int          bad_count, checked, n, h;

   supply_sequencer_fault_config #(.TMO_25MS_US(20), .TMO_50MS_US(40),
      .TMO_100MS_US(80), .TMO_200MS_US(160), .RETRY_25US(5))
   DUT (.clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .in_mv_i, .enable_i, .ramp_done_i, .outputs_low_i,
      .gate_on_o, .fast_pulldown_o, .reverse_down_o, .discharge_en_o,
      .slew_sel_o, .fault_o);

   rail_switch_model rails (.clk_i, .resetn_i, .gate_on_i(gate_on_o),
      .fast_pulldown_i(fast_pulldown_o), .reverse_down_i(reverse_down_o),
      .slew_sel_i(slew_sel_o), .stall_i(stall), .ramp_done_o(ramp_done_i),
      .outputs_low_o(outputs_low_i));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task end_of_test;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test

   task chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task near(input int got, input int exp);
      checked++;
      if (got < exp - TK - 4 || got > exp + TK + 4) begin
         bad_count++;
         $display("[FAIL] %0t took %0d cycles, expected %0d", $time, got, exp);
      end
   endtask : near

   task cyc(input int k);
      repeat (k) @(negedge clk_i);
   endtask : cyc

   function automatic logic sel(input int w);
      case (w)
         0: return gate_on_o;
         1: return ramp_done_i;
         default: return fault_o;
      endcase
   endfunction : sel

   task wait_for(input int w, input logic lvl, input int lim);
      n = 0;
      checked++;
      while (sel(w) !== lvl && n < lim) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= lim) begin
         bad_count++;
         $display("[FAIL] %0t wait on signal %0d ran out", $time, w);
      end
   endtask : wait_for

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge clk_i);
      reg_wr_i = 1'b0;
   endtask : wr

   task rd(input logic [7:0] a);
      @(negedge clk_i);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge clk_i);
      reg_rd_i = 1'b0;
      rd_v = reg_rdata_o;
   endtask : rd

   // enable and wait until the rails report fully up
   task up;
      enable_i = 1'b1;
      wait_for(0, 1'b1, 20);
      wait_for(1, 1'b1, 400);
      cyc(3);
   endtask : up

   initial begin
      #1_000_000;
      bad_count++;
      end_of_test();
   end

   initial begin
      {reg_wr_i, reg_rd_i, enable_i, stall} = 4'h0;
      {reg_addr_i, reg_wdata_i} = 16'h0000;
      in_mv_i = {4{13'h0CE4}};
      bad_count = 0;
      checked = 0;
      resetn_i = 1'b0;
      cyc(2);
      resetn_i = 1'b1;
      foreach (adr[i]) begin
         rd(adr[i]);
         chk(rd_v, 8'h00);
      end
      for (int i = 5; i < 8; i++) wr(8'(i), 8'hC8);
      foreach (adr[i]) wr(adr[i], val[i]);
      foreach (adr[i]) begin
         rd(adr[i]);
         chk(rd_v, (i == 9) ? 8'h00 : val[i]);
      end
      for (int c = 3; c >= 0; c--) begin
         wr(`ADR_RAMP_CFG, {c[1:0], 6'h00});
         cyc(2);
         chk({6'h00, slew_sel_o}, 8'(c));
      end
      for (int i = 0; i < 4; i++) begin
         wr(`ADR_SHUT_CFG, 8'h40 >> i);
         cyc(2);
         chk({4'h0, discharge_en_o}, 8'h01 << i);
      end
      // input 1 at 2.0 V: below coarse trip 3.0 V, inside fine 1.5..2.5 V
      wr(`ADR_LOW_THR0, 8'h64);
      in_mv_i[12:0] = 13'h07D0;
      enable_i = 1'b1;
      cyc(60);
      chk({7'h00, gate_on_o}, 8'h00);
      wr(`ADR_STEP_SEL, 8'h80);
      up();
      rd(`ADR_STATUS);
      chk(rd_v, 8'h04);
      wr(`ADR_SHUT_CFG, 8'h80);
      enable_i = 1'b0;
      cyc(3);
      chk({5'h00, gate_on_o, reverse_down_o, fast_pulldown_o}, 8'h06);
      wait_for(0, 1'b0, 400);
      cyc(3);
      rd(`ADR_STATUS);
      chk(rd_v, 8'h01);
      wr(`ADR_SHUT_CFG, 8'h00);
      up();
      enable_i = 1'b0;
      cyc(3);
      chk({5'h00, gate_on_o, reverse_down_o, fast_pulldown_o}, 8'h01);
      cyc(10);
      for (int c = 0; c < 3; c++) begin
         wr(`ADR_RETRY_CFG, 8'(rty_cd[c] << 2));
         up();
         in_mv_i[25:13] = 13'h03E8;
         cyc(2);
         chk({6'h00, gate_on_o, fault_o}, 8'h01);
         h = rty_us[c] * TK / 2;
         cyc(h);
         chk({6'h00, gate_on_o, fault_o}, 8'h01);
         wait_for(2, 1'b0, 2000);
         near(2 + h + n, rty_us[c] * TK);
         enable_i = 1'b0;
         in_mv_i[25:13] = 13'h0CE4;
         cyc(2);
      end
      wr(`ADR_RETRY_CFG, 8'h20);
      up();
      // input 3 above its 5.0 V high trip
      in_mv_i[38:26] = 13'h1400;
      cyc(2000);
      chk({6'h00, gate_on_o, fault_o}, 8'h01);
      rd(`ADR_STATUS);
      chk(rd_v, 8'h20);
      enable_i = 1'b0;
      in_mv_i[38:26] = 13'h0CE4;
      cyc(3);
      chk({7'h00, fault_o}, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wr(`ADR_TMO_CFG, {c[1:0], 6'h00});
         stall = 1'b1;
         enable_i = 1'b1;
         wait_for(0, 1'b1, 20);
         wait_for(2, 1'b1, 8000);
         near(n, tmo_us[c] * TK);
         chk({6'h00, gate_on_o, fault_o}, 8'h01);
         enable_i = 1'b0;
         stall = 1'b0;
         cyc(3);
      end
      wr(`ADR_SHUT_CFG, 8'h80);
      for (int c = 0; c < 2; c++) begin
         wr(`ADR_TMO_CFG, {2'b00, c[1:0], 4'h0});
         up();
         stall = 1'b1;
         enable_i = 1'b0;
         wait_for(2, 1'b1, 8000);
         near(n, tmo_us[c] * TK);
         stall = 1'b0;
         cyc(300);
      end
      end_of_test();
   end
endmodule : tb_top

`default_nettype wire
